// ===== design/bdm_core.sv
// What this block does
// [RULE_01] Data memory is thirty-two banks of 128 bytes each.
// [RULE_02] Direct accesses use the bank last written to bank select.
// [RULE_03] Reads of unimplemented locations return zero.
// [RULE_04] All memory reachable directly and through either indirect pointer.
// [RULE_05] Twelve core registers sit at offsets 0-11 of every bank.
// [RULE_06] Core 00-0B, peripheral 0C-1F, general 20-6F, common 70-7F.
// [RULE_07] At most eighty bytes of general RAM per bank.
// [RULE_08] Sixteen common bytes are one storage shared by all banks.
// [RULE_09] General RAM also reachable linearly through the pointers.
// [RULE_10] Status may be the destination of any instruction.
// [RULE_11] Flag-affecting instruction writing status keeps its own flag results.
// [RULE_12] Expiry and power-down flags ignore software writes.
// [RULE_13] Status bits 7 to 5 always read zero.
// [RULE_14] Bit 4 set by power-up, kick, sleep; cleared by watchdog time-out.
// [RULE_15] Bit 3 set by power-up or kick; cleared by sleep.
// [RULE_16] Bit 2 set when the operation result is zero.
// [RULE_17] Bit 1 is carry out of the low nibble on add/subtract.
// [RULE_18] Bit 0 is carry out of the top bit on add/subtract.
// [RULE_19] Subtract adds two's complement; carries act as inverted borrows.
// [RULE_20] Rotates through carry load carry from the bit shifted out.
// [RULE_21] Power-on reset: hardware flags one, arithmetic flags zero; soft keeps.
// [RULE_22] Direct address is bank number joined with seven-bit offset.
`timescale 1ns/1ps
`default_nettype none
`include "bdm_defines.svh"

module bdm_core (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic soft_rst,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_indirect,
  input wire logic req_ptr_sel,
  input wire logic [`BDM_OFS_W-1:0] req_offset,
  input wire logic [7:0] req_wdata,
  input wire logic req_use_alu,
  input wire bdm_pkg::bdm_alu_op_type alu_op,
  input wire logic [7:0] alu_opnd_a,
  input wire logic [7:0] alu_opnd_b,
  input wire logic watchdog_timeout,
  input wire logic kick_instr,
  input wire logic sleep_instr,
  output logic rd_valid,
  output logic [7:0] rd_data,
  output logic [7:0] alu_result,
  output logic [7:0] status_out,
  output logic [`BDM_BANK_W-1:0] bank_out
);
  import bdm_pkg::*;

  bdm_mem_if mem_bus ();

  logic expiry_r, expiry_nxt;
  logic pdown_r, pdown_nxt;
  logic [2:0] arith_r, arith_nxt;
  logic [`BDM_BANK_W-1:0] bank_select_reg_r, bank_select_reg_nxt;
  logic [15:0] ptr_r [2];
  logic [15:0] ptr_nxt [2];
  logic [7:0] misc_r [4];
  logic [7:0] misc_nxt [4];
  logic rd_valid_r, rd_valid_nxt;
  logic [7:0] rd_data_r, rd_data_nxt;
  logic [7:0] alu_res_r, alu_res_nxt;

  logic [7:0] alu_res;
  logic [2:0] alu_flags;
  logic [2:0] alu_mask;
  logic [7:0] wr_byte;
  logic [7:0] status_rd;
  logic [7:0] core_rd;
  logic [15:0] eff_addr;
  logic [`BDM_BANK_W-1:0] eff_bank;
  logic [`BDM_OFS_W-1:0] eff_ofs;
  logic [`BDM_GEN_IDX_W-1:0] gen_idx;
  logic [`BDM_GEN_IDX_W-1:0] lin_idx;
  logic [15:0] lin_ofs;
  bdm_region_type region;
  logic use_ptr;
  logic ptr_sel;
  logic via_ptr;
  logic do_wr;
  logic do_rd;
  logic st_wr;

  bdm_alu u_alu (
    .op(alu_op),
    .opnd_a(alu_opnd_a),
    .opnd_b(alu_opnd_b),
    .carry_in(arith_r[`BDM_ST_C]),
    .result(alu_res),
    .flags(alu_flags),
    .flag_mask(alu_mask)
  );

  bdm_ram u_ram (
    .core_clk(core_clk),
    .mem(mem_bus.mem)
  );

  // address decode
  always_comb begin
    // offsets 0 and 1 of any bank are the indirect data windows
    use_ptr = req_indirect || (req_offset == `BDM_OFS_IND0) ||
              (req_offset == `BDM_OFS_IND1); // [RULE_04]
    ptr_sel = req_indirect ? req_ptr_sel : req_offset[0];
    eff_addr = use_ptr ? ptr_r[ptr_sel] :
               {4'h0, bank_select_reg_r, req_offset}; // [RULE_22] [RULE_02]
    eff_bank = eff_addr[11:7];
    eff_ofs = eff_addr[6:0];
    via_ptr = use_ptr;
    // full-width subtract, then keep only the index bits on purpose
    lin_ofs = eff_addr - `BDM_PTR_LINEAR_BASE;
    lin_idx = lin_ofs[`BDM_GEN_IDX_W-1:0];
    // bank*80 + (offset-0x20), same index the linear window uses
    gen_idx = {1'b0, eff_bank, 6'h00} + {3'h0, eff_bank, 4'h0} +
              {5'h00, eff_ofs} - {5'h00, `BDM_OFS_GEN};
    region = BDM_REG_NONE;
    if (eff_addr < `BDM_PTR_BANKED_TOP) begin // [RULE_01]
      if (eff_ofs < `BDM_OFS_PERIPH) begin
        region = BDM_REG_CORE; // [RULE_05]
      end else if (eff_ofs < `BDM_OFS_GEN) begin
        region = BDM_REG_PERIPH; // [RULE_06]
      end else if (eff_ofs < `BDM_OFS_COMMON) begin
        region = BDM_REG_GEN; // [RULE_06]
      end else begin
        region = BDM_REG_COMMON; // [RULE_06]
      end
    end else if (eff_addr >= `BDM_PTR_LINEAR_BASE &&
                 eff_addr < `BDM_PTR_LINEAR_TOP) begin
      region = BDM_REG_GEN; // [RULE_09]
      gen_idx = lin_idx;
    end
    // a pointer aimed at a data window is not followed a second time
    if (region == BDM_REG_CORE && via_ptr &&
        (eff_ofs == `BDM_OFS_IND0 || eff_ofs == `BDM_OFS_IND1)) begin
      region = BDM_REG_NONE;
    end
    do_wr = req_valid && req_write;
    do_rd = req_valid && !req_write;
    st_wr = do_wr && region == BDM_REG_CORE && eff_ofs == `BDM_OFS_STATUS;
    wr_byte = req_use_alu ? alu_res : req_wdata;
  end

  assign mem_bus.gen_we = do_wr && region == BDM_REG_GEN;
  assign mem_bus.com_we = do_wr && region == BDM_REG_COMMON; // [RULE_08]
  assign mem_bus.gen_idx = gen_idx;
  assign mem_bus.com_idx = eff_ofs[`BDM_COM_IDX_W-1:0];
  assign mem_bus.wdata = wr_byte;

  always_comb begin
    status_rd = {3'b000, expiry_r, pdown_r, arith_r}; // [RULE_13]
    core_rd = `BDM_RST_BYTE;
    unique case (eff_ofs)
      `BDM_OFS_STATUS: core_rd = status_rd;
      `BDM_OFS_PTR0_LO: core_rd = ptr_r[0][7:0];
      `BDM_OFS_PTR0_HI: core_rd = ptr_r[0][15:8];
      `BDM_OFS_PTR1_LO: core_rd = ptr_r[1][7:0];
      `BDM_OFS_PTR1_HI: core_rd = ptr_r[1][15:8];
      `BDM_OFS_BANK: core_rd = {3'b000, bank_select_reg_r};
      `BDM_OFS_PC_LOW: core_rd = misc_r[0];
      `BDM_OFS_WORK: core_rd = misc_r[1];
      `BDM_OFS_PC_LATCH: core_rd = misc_r[2];
      `BDM_OFS_INT_CTRL: core_rd = misc_r[3];
      default: core_rd = `BDM_RST_BYTE;
    endcase
  end

  always_comb begin
    expiry_nxt = expiry_r;
    pdown_nxt = pdown_r;
    arith_nxt = arith_r;
    bank_select_reg_nxt = bank_select_reg_r;
    ptr_nxt = ptr_r;
    misc_nxt = misc_r;
    alu_res_nxt = req_valid && req_use_alu ? alu_res : alu_res_r;
    rd_valid_nxt = do_rd;
    rd_data_nxt = `BDM_RST_BYTE;
    if (do_rd) begin
      unique case (region)
        BDM_REG_CORE: rd_data_nxt = core_rd;
        BDM_REG_GEN: rd_data_nxt = mem_bus.gen_rdata;
        BDM_REG_COMMON: rd_data_nxt = mem_bus.com_rdata;
        default: rd_data_nxt = `BDM_RST_BYTE; // [RULE_03]
      endcase
    end
    if (do_wr && region == BDM_REG_CORE) begin
      unique case (eff_ofs)
        `BDM_OFS_PTR0_LO: ptr_nxt[0][7:0] = wr_byte;
        `BDM_OFS_PTR0_HI: ptr_nxt[0][15:8] = wr_byte;
        `BDM_OFS_PTR1_LO: ptr_nxt[1][7:0] = wr_byte;
        `BDM_OFS_PTR1_HI: ptr_nxt[1][15:8] = wr_byte;
        `BDM_OFS_BANK:
          bank_select_reg_nxt = wr_byte[`BDM_BANK_W-1:0]; // [RULE_02]
        `BDM_OFS_PC_LOW: misc_nxt[0] = wr_byte;
        `BDM_OFS_WORK: misc_nxt[1] = wr_byte;
        `BDM_OFS_PC_LATCH: misc_nxt[2] = wr_byte;
        `BDM_OFS_INT_CTRL: misc_nxt[3] = wr_byte;
        default: misc_nxt = misc_r;
      endcase
    end
    // status write: flags the operation owns are not overwritten
    for (int i = 0; i < 3; i++) begin
      if (req_valid && req_use_alu && alu_mask[i]) begin
        arith_nxt[i] = alu_flags[i]; // [RULE_11] [RULE_16]
      end else if (st_wr && !(req_use_alu && alu_mask != 3'b000)) begin
        arith_nxt[i] = wr_byte[i]; // [RULE_10]
      end
    end
    // hardware events only; the software byte never reaches bits 4 and 3
    if (kick_instr) begin // [RULE_12]
      expiry_nxt = 1'b1; // [RULE_14]
      pdown_nxt = 1'b1; // [RULE_15]
    end else if (sleep_instr) begin
      expiry_nxt = 1'b1; // [RULE_14]
      pdown_nxt = 1'b0; // [RULE_15]
    end
    if (watchdog_timeout) begin
      expiry_nxt = 1'b0; // [RULE_14]
    end
    if (soft_rst) begin
      // arithmetic flags and hardware flags ride through a soft reset
      bank_select_reg_nxt = `BDM_RST_BANK;
      ptr_nxt[0] = `BDM_RST_PTR;
      ptr_nxt[1] = `BDM_RST_PTR;
      rd_valid_nxt = 1'b0;
      // data is only ever shown together with its valid pulse
      rd_data_nxt = `BDM_RST_BYTE;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      expiry_r <= `BDM_RST_HW_FLAG; // [RULE_21]
      pdown_r <= `BDM_RST_HW_FLAG; // [RULE_21]
      arith_r <= {3{`BDM_RST_ARITH}}; // [RULE_21]
      bank_select_reg_r <= `BDM_RST_BANK;
      ptr_r[0] <= `BDM_RST_PTR;
      ptr_r[1] <= `BDM_RST_PTR;
      for (int i = 0; i < 4; i++) begin
        misc_r[i] <= `BDM_RST_BYTE;
      end
      rd_valid_r <= 1'b0;
      rd_data_r <= `BDM_RST_BYTE;
      alu_res_r <= `BDM_RST_BYTE;
    end else begin
      expiry_r <= expiry_nxt;
      pdown_r <= pdown_nxt;
      arith_r <= arith_nxt;
      bank_select_reg_r <= bank_select_reg_nxt;
      ptr_r <= ptr_nxt;
      misc_r <= misc_nxt;
      rd_valid_r <= rd_valid_nxt;
      rd_data_r <= rd_data_nxt;
      alu_res_r <= alu_res_nxt;
    end
  end

  assign rd_valid = rd_valid_r;
  assign rd_data = rd_data_r;
  assign alu_result = alu_res_r;
  assign status_out = status_rd;
  assign bank_out = bank_select_reg_r;

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  status_top_zero_a: // [RULE_13]
    assert property (do_rd && !soft_rst && region == BDM_REG_CORE &&
      eff_ofs == `BDM_OFS_STATUS |=> rd_data[7:5] == 3'b000)
    else $error("status upper bits not zero");

  unimpl_zero_a: // [RULE_03]
    assert property (do_rd && (region == BDM_REG_PERIPH ||
      region == BDM_REG_NONE) && !soft_rst |=> rd_valid && rd_data == 8'h00)
    else $error("unimplemented location read nonzero");

  bank_write_a: // [RULE_02]
    assert property (do_wr && region == BDM_REG_CORE && !soft_rst &&
      eff_ofs == `BDM_OFS_BANK |=> bank_out == $past(wr_byte[4:0]))
    else $error("bank select not loaded");

  kick_flags_a: // [RULE_15]
    assert property (kick_instr && !watchdog_timeout |=>
      status_out[4:3] == 2'b11)
    else $error("kick did not set both flags");

  sleep_flags_a: // [RULE_14]
    assert property (sleep_instr && !kick_instr && !watchdog_timeout |=>
      status_out[4:3] == 2'b10)
    else $error("sleep flag pattern wrong");

  timeout_clear_a: // [RULE_14]
    assert property (watchdog_timeout |=> !status_out[4])
    else $error("time-out did not clear expiry flag");

  hw_flags_held_a: // [RULE_12]
    assert property (!kick_instr && !sleep_instr && !watchdog_timeout |=>
      $stable(status_out[4:3]))
    else $error("hardware flags moved without cause");

  flag_wins_a: // [RULE_11]
    assert property (st_wr && req_use_alu && alu_mask[`BDM_ST_Z] |=>
      status_out[2] == $past(alu_flags[`BDM_ST_Z]))
    else $error("status write overrode zero flag");

  read_latency_a: // [RULE_04]
    assert property (do_rd && !soft_rst |=> rd_valid ##1 !rd_valid ||
      $past(do_rd))
    else $error("read answer not one cycle later");
endmodule

`default_nettype wire

// ===== design/bdm_defines.svh
`ifndef BDM_DEFINES_SVH
`define BDM_DEFINES_SVH

// data memory geometry
`define BDM_NUM_BANKS 32
`define BDM_BANK_BYTES 128
`define BDM_GEN_PER_BANK 80
`define BDM_COMMON_BYTES 16
`define BDM_CORE_COUNT 12
`define BDM_BANK_W 5
`define BDM_OFS_W 7
`define BDM_GEN_IDX_W 12
`define BDM_COM_IDX_W 4

// in-bank region boundaries
`define BDM_OFS_PERIPH 7'h0c
`define BDM_OFS_GEN 7'h20
`define BDM_OFS_COMMON 7'h70

// core register offsets
`define BDM_OFS_IND0 7'h00
`define BDM_OFS_IND1 7'h01
`define BDM_OFS_PC_LOW 7'h02
`define BDM_OFS_STATUS 7'h03
`define BDM_OFS_PTR0_LO 7'h04
`define BDM_OFS_PTR0_HI 7'h05
`define BDM_OFS_PTR1_LO 7'h06
`define BDM_OFS_PTR1_HI 7'h07
`define BDM_OFS_BANK 7'h08
`define BDM_OFS_WORK 7'h09
`define BDM_OFS_PC_LATCH 7'h0a
`define BDM_OFS_INT_CTRL 7'h0b

// pointer address space
`define BDM_PTR_BANKED_TOP 16'h1000
`define BDM_PTR_LINEAR_BASE 16'h2000
`define BDM_PTR_LINEAR_TOP 16'h2a00

// status bit positions
`define BDM_ST_C 0
`define BDM_ST_NIBBLE 1
`define BDM_ST_Z 2
`define BDM_ST_PDOWN 3
`define BDM_ST_EXPIRY 4

// reset values
`define BDM_RST_BYTE 8'h00
`define BDM_RST_BANK 5'h00
`define BDM_RST_PTR 16'h0000
`define BDM_RST_HW_FLAG 1'b1
`define BDM_RST_ARITH 1'b0

`endif

// ===== design/bdm_pkg.sv
`default_nettype none

package bdm_pkg;

  typedef enum logic [2:0] {
    BDM_ALU_PASS = 3'b000,
    BDM_ALU_LOGIC = 3'b001,
    BDM_ALU_ADD = 3'b010,
    BDM_ALU_SUB = 3'b011,
    BDM_ALU_ROTL = 3'b100,
    BDM_ALU_ROTR = 3'b101,
    BDM_ALU_CLEAR = 3'b110
  } bdm_alu_op_type;

  typedef enum logic [2:0] {
    BDM_REG_CORE = 3'b000,
    BDM_REG_PERIPH = 3'b001,
    BDM_REG_GEN = 3'b010,
    BDM_REG_COMMON = 3'b011,
    BDM_REG_NONE = 3'b100
  } bdm_region_type;

endpackage

`default_nettype wire

// ===== design/bdm_mem_if.sv
`timescale 1ns/1ps
`default_nettype none
`include "bdm_defines.svh"

interface bdm_mem_if;
  logic gen_we;
  logic com_we;
  logic [`BDM_GEN_IDX_W-1:0] gen_idx;
  logic [`BDM_COM_IDX_W-1:0] com_idx;
  logic [7:0] wdata;
  logic [7:0] gen_rdata;
  logic [7:0] com_rdata;

  modport ctrl (
    output gen_we,
    output com_we,
    output gen_idx,
    output com_idx,
    output wdata,
    input gen_rdata,
    input com_rdata
  );

  modport mem (
    input gen_we,
    input com_we,
    input gen_idx,
    input com_idx,
    input wdata,
    output gen_rdata,
    output com_rdata
  );
endinterface

`default_nettype wire

// ===== design/bdm_ram.sv
`timescale 1ns/1ps
`default_nettype none
`include "bdm_defines.svh"

module bdm_ram #(
  parameter int NUM_BANKS = `BDM_NUM_BANKS,
  parameter int GEN_PER_BANK = `BDM_GEN_PER_BANK,
  parameter int COMMON_BYTES = `BDM_COMMON_BYTES
) (
  input wire logic core_clk,
  bdm_mem_if.mem mem
);
  import bdm_pkg::*;

  localparam int GEN_BYTES = NUM_BANKS * GEN_PER_BANK;

  // storage is not reset: ram content is undefined after power-up
  logic [7:0] gen_mem [GEN_BYTES];
  // one copy only, every bank window lands here
  logic [7:0] com_mem [COMMON_BYTES];

  always_ff @(posedge core_clk) begin
    if (mem.gen_we) begin
      gen_mem[mem.gen_idx] <= mem.wdata; // [RULE_07]
    end
    if (mem.com_we) begin
      com_mem[mem.com_idx] <= mem.wdata; // [RULE_08]
    end
  end

  assign mem.gen_rdata = gen_mem[mem.gen_idx];
  assign mem.com_rdata = com_mem[mem.com_idx];
endmodule

`default_nettype wire

// ===== design/bdm_alu.sv
`timescale 1ns/1ps
`default_nettype none
`include "bdm_defines.svh"

module bdm_alu (
  input wire bdm_pkg::bdm_alu_op_type op,
  input wire logic [7:0] opnd_a,
  input wire logic [7:0] opnd_b,
  input wire logic carry_in,
  output logic [7:0] result,
  output logic [2:0] flags,
  output logic [2:0] flag_mask
);
  import bdm_pkg::*;

  logic [8:0] sum;
  logic [4:0] low_sum;
  logic [7:0] addend;
  logic cin;

  always_comb begin
    // subtract is a plus the two's complement of b
    addend = (op == BDM_ALU_SUB) ? ~opnd_b : opnd_b; // [RULE_19]
    cin = (op == BDM_ALU_SUB);
    sum = {1'b0, opnd_a} + {1'b0, addend} + {8'h00, cin};
    low_sum = {1'b0, opnd_a[3:0]} + {1'b0, addend[3:0]} + {4'h0, cin};
    result = opnd_a;
    flags = 3'b000;
    flag_mask = 3'b000;
    unique case (op)
      BDM_ALU_PASS: begin
        result = opnd_a;
      end
      BDM_ALU_LOGIC: begin
        result = opnd_a;
        flag_mask[`BDM_ST_Z] = 1'b1;
      end
      BDM_ALU_ADD, BDM_ALU_SUB: begin
        result = sum[7:0];
        // carries double as inverted borrows on subtract
        flags[`BDM_ST_NIBBLE] = low_sum[4]; // [RULE_17]
        flags[`BDM_ST_C] = sum[8]; // [RULE_18]
        flag_mask = 3'b111;
      end
      BDM_ALU_ROTL: begin
        result = {opnd_a[6:0], carry_in};
        flags[`BDM_ST_C] = opnd_a[7]; // [RULE_20]
        flag_mask[`BDM_ST_C] = 1'b1;
      end
      BDM_ALU_ROTR: begin
        result = {carry_in, opnd_a[7:1]};
        flags[`BDM_ST_C] = opnd_a[0]; // [RULE_20]
        flag_mask[`BDM_ST_C] = 1'b1;
      end
      BDM_ALU_CLEAR: begin
        result = 8'h00;
        flag_mask[`BDM_ST_Z] = 1'b1;
      end
      default: begin
        result = opnd_a;
      end
    endcase
    flags[`BDM_ST_Z] = (result == 8'h00); // [RULE_16]
  end
endmodule

`default_nettype wire

// ===== verification/bdm_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none

module bdm_cpu_model (
  input wire logic core_clk,
  output var logic soft_rst,
  output var logic req_valid,
  output var logic req_write,
  output var logic req_indirect,
  output var logic req_ptr_sel,
  output var logic [6:0] req_offset,
  output var logic [7:0] req_wdata,
  output var logic req_use_alu,
  output var bdm_pkg::bdm_alu_op_type alu_op,
  output var logic [7:0] alu_opnd_a,
  output var logic [7:0] alu_opnd_b,
  output var logic watchdog_timeout,
  output var logic kick_instr,
  output var logic sleep_instr
);
  import bdm_pkg::*;

  initial begin
    {soft_rst, req_valid, req_write, req_indirect} = 4'h0;
    {req_ptr_sel, req_use_alu, watchdog_timeout} = 3'h0;
    {kick_instr, sleep_instr} = 2'h0;
    {req_offset, req_wdata} = 15'h0000;
    {alu_opnd_a, alu_opnd_b} = 16'h0000;
    alu_op = BDM_ALU_PASS;
  end

  // one instruction per call; valid drops and write, offset, data and operands swing to the inverse afterwards
  // so a stale qualifier is never read as a fresh one
  task automatic issue(input logic w, ind, ps, alu,
    input logic [6:0] ofs, input logic [7:0] d,
    input bdm_alu_op_type op, input logic [7:0] a, b);
    @(negedge core_clk);
    {req_valid, req_write, req_indirect} = {1'b1, w, ind};
    {req_ptr_sel, req_use_alu} = {ps, alu};
    alu_op = op;
    {req_offset, req_wdata} = {ofs, d};
    {alu_opnd_a, alu_opnd_b} = {a, b};
    @(negedge core_clk);
    {req_valid, req_use_alu, req_write} = {2'b00, ~w};
    {req_offset, req_wdata} = ~{ofs, d};
    {alu_opnd_a, alu_opnd_b} = ~{a, b};
  endtask

  // k: soft reset, watchdog expiry, kick, sleep (msb first)
  task automatic pulse(input logic [3:0] k);
    @(negedge core_clk);
    {soft_rst, watchdog_timeout, kick_instr, sleep_instr} = k;
    @(negedge core_clk);
    {soft_rst, watchdog_timeout, kick_instr, sleep_instr} = 4'h0;
  endtask
endmodule

`default_nettype wire

// ===== verification/banked_data_memory_status_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "bdm_defines.svh"

module banked_data_memory_status_test;
  import bdm_pkg::*;
  logic core_clk, rst, soft_rst, req_valid, req_write, req_indirect;
  logic req_ptr_sel, req_use_alu, watchdog_timeout, kick_instr, sleep_instr;
  logic rd_valid;
  logic [6:0] req_offset;
  logic [7:0] req_wdata, alu_opnd_a, alu_opnd_b, rd_data, alu_result;
  logic [7:0] status_out;
  logic [4:0] bank_out;
  bdm_alu_op_type alu_op;
  int fails = 0;
  int check_count = 0;
  int cycles = 0;

  bdm_cpu_model i_bdm_cpu_model (.core_clk, .soft_rst, .req_valid,
    .req_write, .req_indirect, .req_ptr_sel, .req_offset, .req_wdata,
    .req_use_alu, .alu_op, .alu_opnd_a, .alu_opnd_b, .watchdog_timeout,
    .kick_instr, .sleep_instr);

  bdm_core i_bdm_core (.core_clk, .rst, .soft_rst, .req_valid,
    .req_write, .req_indirect, .req_ptr_sel, .req_offset, .req_wdata,
    .req_use_alu, .alu_op, .alu_opnd_a, .alu_opnd_b, .watchdog_timeout,
    .kick_instr, .sleep_instr, .rd_valid, .rd_data, .alu_result,
    .status_out, .bank_out);

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // the whole sequence needs well under 200 cycles
  always @(posedge core_clk) begin
    cycles = cycles + 1;
    if (cycles == 1000) begin
      fails = fails + 1;
      test_done();
    end
  end

  task automatic chk(input logic [7:0] got, exp);
    check_count = check_count + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [6:0] o, input logic [7:0] d);
    i_bdm_cpu_model.issue(1'b1, 1'b0, 1'b0, 1'b0, o, d, BDM_ALU_PASS,
      8'h00, 8'h00);
  endtask

  // answer stands for the one cycle after the taking edge
  task automatic rd(input logic ind, ps, input logic [6:0] o,
    input logic [7:0] e);
    i_bdm_cpu_model.issue(1'b0, ind, ps, 1'b0, o, 8'h00, BDM_ALU_PASS,
      8'h00, 8'h00);
    chk({7'h00, rd_valid}, 8'h01);
    chk(rd_data, e);
  endtask

  task automatic alu(input logic [6:0] o, input bdm_alu_op_type op,
    input logic [7:0] a, b, r, f);
    i_bdm_cpu_model.issue(1'b1, 1'b0, 1'b0, 1'b1, o, 8'h00, op, a, b);
    chk(alu_result, r);
    chk(status_out, f);
  endtask

  initial begin
    rst = 1'b1;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'b0;
    chk(status_out, 8'h18);
    chk({3'h0, bank_out}, 8'h00);
    wr(`BDM_OFS_BANK, 8'h03);
    chk({3'h0, bank_out}, 8'h03);
    wr(7'h20, 8'ha3);
    wr(7'h70, 8'hc7);
    wr(7'h6f, 8'h6f);
    wr(`BDM_OFS_BANK, 8'h05);
    wr(7'h20, 8'ha5);
    rd(1'b0, 1'b0, 7'h70, 8'hc7);
    @(negedge core_clk);
    chk({7'h00, rd_valid}, 8'h00);
    rd(1'b0, 1'b0, 7'h20, 8'ha5);
    wr(`BDM_OFS_BANK, 8'h03);
    rd(1'b0, 1'b0, 7'h20, 8'ha3);
    rd(1'b0, 1'b0, 7'h6f, 8'h6f);
    // peripheral range at its first and last offset holds nothing here
    wr(7'h0c, 8'h55);
    rd(1'b0, 1'b0, 7'h0c, 8'h00);
    rd(1'b0, 1'b0, 7'h1f, 8'h00);
    // linear 0x20f0 is bank 3 offset 0x20 (3 * 80 = 0xf0)
    wr(`BDM_OFS_PTR0_LO, 8'hf0);
    wr(`BDM_OFS_PTR0_HI, 8'h20);
    rd(1'b1, 1'b0, 7'h00, 8'ha3);
    rd(1'b0, 1'b0, `BDM_OFS_IND0, 8'ha3);
    wr(`BDM_OFS_PTR1_LO, 8'ha0);
    wr(`BDM_OFS_PTR1_HI, 8'h02);
    rd(1'b1, 1'b1, 7'h00, 8'ha5);
    rd(1'b0, 1'b0, `BDM_OFS_IND1, 8'ha5);
    wr(`BDM_OFS_PTR0_LO, 8'h00);
    wr(`BDM_OFS_PTR0_HI, 8'h2a);
    rd(1'b1, 1'b0, 7'h00, 8'h00);
    rd(1'b0, 1'b0, `BDM_OFS_PTR0_HI, 8'h2a);
    wr(`BDM_OFS_WORK, 8'h5a);
    wr(`BDM_OFS_BANK, 8'h1f);
    rd(1'b0, 1'b0, `BDM_OFS_WORK, 8'h5a);
    rd(1'b0, 1'b0, `BDM_OFS_BANK, 8'h1f);
    wr(`BDM_OFS_STATUS, 8'hff);
    chk(status_out, 8'h1f);
    rd(1'b0, 1'b0, `BDM_OFS_STATUS, 8'h1f);
    wr(`BDM_OFS_STATUS, 8'h00);
    alu(`BDM_OFS_WORK, BDM_ALU_ADD, 8'h0f, 8'h01, 8'h10, 8'h1a);
    alu(`BDM_OFS_WORK, BDM_ALU_ADD, 8'hff, 8'h01, 8'h00, 8'h1f);
    alu(`BDM_OFS_WORK, BDM_ALU_SUB, 8'h05, 8'h03, 8'h02, 8'h1b);
    alu(`BDM_OFS_WORK, BDM_ALU_SUB, 8'h03, 8'h05, 8'hfe, 8'h18);
    alu(`BDM_OFS_WORK, BDM_ALU_ROTL, 8'h81, 8'h00, 8'h02, 8'h19);
    alu(`BDM_OFS_WORK, BDM_ALU_ROTR, 8'h01, 8'h00, 8'h80, 8'h19);
    alu(`BDM_OFS_WORK, BDM_ALU_LOGIC, 8'h00, 8'h00, 8'h00, 8'h1d);
    // a flag-neutral operation aimed at status writes bits 2:0 as data
    alu(`BDM_OFS_STATUS, BDM_ALU_PASS,
      8'h02, 8'h00, 8'h02, 8'h1a);
    wr(`BDM_OFS_STATUS, 8'h03);
    chk(status_out, 8'h1b);
    // clearing the flags register sets zero but keeps both carries
    alu(`BDM_OFS_STATUS, BDM_ALU_CLEAR,
      8'h00, 8'h00, 8'h00, 8'h1f);
    i_bdm_cpu_model.pulse(4'h1);
    chk(status_out, 8'h17);
    i_bdm_cpu_model.pulse(4'h4);
    chk(status_out, 8'h07);
    wr(`BDM_OFS_STATUS, 8'hff);
    chk(status_out, 8'h07);
    i_bdm_cpu_model.pulse(4'h8);
    chk(status_out, 8'h07);
    chk({3'h0, bank_out}, 8'h00);
    rd(1'b0, 1'b0, `BDM_OFS_PTR0_HI, 8'h00);
    i_bdm_cpu_model.pulse(4'h2);
    chk(status_out, 8'h1f);
    wr(`BDM_OFS_BANK, 8'h0a);
    @(negedge core_clk);
    rst = 1'b1;
    @(negedge core_clk);
    chk(status_out, 8'h18);
    chk({3'h0, bank_out}, 8'h00);
    rst = 1'b0;
    rd(1'b0, 1'b0, `BDM_OFS_BANK, 8'h00);
    test_done();
  end
endmodule

`default_nettype wire
